// file: hdl/smh_defs.svh
// Constants of the submessage header framer: kind codes, flag bit
// positions, header layout and reset values.
// Assumes inclusion by its bare name from package and design files.
`ifndef SMH_DEFS_SVH
`define SMH_DEFS_SVH

// Kind codes that the framer knows by name.
`define SMH_KIND_PAD 8'h01
`define SMH_KIND_ACKNACK 8'h06
`define SMH_KIND_HEARTBEAT 8'h07
`define SMH_KIND_GAP 8'h08
`define SMH_KIND_INFO_TS 8'h09
`define SMH_KIND_INFO_SRC 8'h0C
`define SMH_KIND_INFO_RIP4 8'h0D
`define SMH_KIND_INFO_DST 8'h0E
`define SMH_KIND_INFO_REPLY 8'h0F
`define SMH_KIND_NACK_FRAG 8'h12
`define SMH_KIND_HB_FRAG 8'h13
`define SMH_KIND_DATA 8'h15
`define SMH_KIND_DATA_FRAG 8'h16

// Flag bit positions inside the flags octet.
`define SMH_FLG_ENDIAN 0
`define SMH_FLG_FINAL 1
`define SMH_FLG_LIVE 2
`define SMH_FLG_QOS 1
`define SMH_FLG_DATA 2
`define SMH_FLG_KEY 3
`define SMH_FLG_NSTD 4

// Header layout: byte indices and sizes.
`define SMH_HDR_KIND 2'h0
`define SMH_HDR_FLAGS 2'h1
`define SMH_HDR_LEN_A 2'h2
`define SMH_HDR_LEN_B 2'h3
`define SMH_XFL_LEN 16'h0002
`define SMH_XFL_BYTE 8'h00

// Reset values.
`define SMH_RST_BYTE 8'h00
`define SMH_RST_WORD 16'h0000

`endif

// file: hdl/smh_pkg.sv
// Types shared by the submessage header framer files.
// Assumes smh_defs.svh sits on the include path.
`include "smh_defs.svh"

package smh_pkg;

    // Framer states.
    typedef enum logic [1:0] {
        SMH_IDLE = 2'b00,
        SMH_HDR = 2'b01,
        SMH_XFL = 2'b10,
        SMH_BODY = 2'b11
    } smh_state_t;

    // Complete state of the framer.
    typedef struct packed {
        smh_state_t st;
        logic [1:0] idx;
        logic [15:0] rem;
        logic [7:0] kind;
        logic [7:0] flg;
        logic [15:0] len;
        logic le;
        logic xflg;
        logic open_end;
        logic [7:0] dat;
        logic vld;
        logic lst;
        logic hb_owed;
        logic err;
    } smh_regs_t;

endpackage

// file: hdl/smh_flag_build.sv
// Flags octet builder: places each flag at its bit for the given kind.
// Assumes purely combinational use inside the framer.
`timescale 1ns/100ps
`include "smh_defs.svh"

module smh_flag_build
    import smh_pkg::*;
(
    input wire logic [7:0] kind,
    input wire logic le,
    input wire logic fin,
    input wire logic live,
    input wire logic qos,
    input wire logic dpres,
    input wire logic kpres,
    input wire logic nstd,
    output logic [7:0] flags
);

    // Bits not defined for a kind stay zero; endianness is always bit 0.
    always_comb begin
        flags = `SMH_RST_BYTE;
        flags[`SMH_FLG_ENDIAN] = le;
        case (kind)
            `SMH_KIND_ACKNACK: begin
                flags[`SMH_FLG_FINAL] = fin;
            end
            `SMH_KIND_HEARTBEAT: begin
                flags[`SMH_FLG_FINAL] = fin;
                flags[`SMH_FLG_LIVE] = live;
            end
            `SMH_KIND_DATA: begin
                flags[`SMH_FLG_QOS] = qos;
                flags[`SMH_FLG_DATA] = dpres;
                flags[`SMH_FLG_KEY] = kpres;
                flags[`SMH_FLG_NSTD] = nstd;
            end
            default: begin
                flags[`SMH_FLG_ENDIAN] = le;
            end
        endcase
    end

endmodule

// file: hdl/smh_framer.sv
// Submessage framer: turns a user request into a header, optional
// extra-flags field and body bytes on an octet stream.
// Assumes user ports and tx_ready come from logic on ref_clk.
//
// Behaviour
// - Header: kind, flags, 16-bit length, contents.
// - Length counts contents up to next header.
// - Named kind codes have fixed values.
// - Flags bit 0 selects byte order.
// - Unused flag bits sent zero, ignored.
// - Zero length marks last submessage; framer sends header only unless req_last is set on a kind other than pad or timestamp.
// - Acknack final clear demands a heartbeat.
// - Data flags bit 1: inline QoS present.
// - Data flags bit 2: data present.
// - Data flags bit 3: key present.
// - Data extra flags sent as zero.
`timescale 1ns/100ps
`include "smh_defs.svh"

module smh_framer
    import smh_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_kind,
    input wire logic [15:0] req_len,
    input wire logic req_last,
    input wire logic req_le,
    input wire logic req_fin,
    input wire logic req_live,
    input wire logic req_qos,
    input wire logic req_dpres,
    input wire logic req_kpres,
    input wire logic req_nstd,
    output logic req_err,
    input wire logic pl_valid,
    output logic pl_ready,
    input wire logic [7:0] pl_data,
    input wire logic pl_last,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic ack_rcv,
    input wire logic ack_final,
    output logic hb_owed
);

    ////////////////////////////////////////////////////////////////////
    smh_regs_t q;
    smh_regs_t n;
    logic [7:0] flag_octet;
    logic adv;
    logic bad;
    logic zero_ok;

    // Flags octet for the request at the user port.
    smh_flag_build u_flags (
        .kind(req_kind),
        .le(req_le),
        .fin(req_fin),
        .live(req_live),
        .qos(req_qos),
        .dpres(req_dpres),
        .kpres(req_kpres),
        .nstd(req_nstd),
        .flags(flag_octet)
    );

    // Handshakes; the output register advances when empty or taken.
    assign adv = !q.vld || tx_ready;
    assign req_ready = ce && (q.st == SMH_IDLE);
    assign pl_ready = ce && (q.st == SMH_BODY) && adv;
    assign tx_valid = ce && q.vld;
    assign tx_data = q.dat;
    assign tx_last = q.lst;
    assign hb_owed = q.hb_owed;
    assign req_err = q.err;

    // Pad and timestamp may carry a zero length without ending a message.
    assign zero_ok = (req_kind == `SMH_KIND_PAD) ||
        (req_kind == `SMH_KIND_INFO_TS);
    // Both payload kinds at once, or too short for extra flags, refused.
    assign bad = (req_kind == `SMH_KIND_DATA) &&
        ((req_dpres && req_kpres) ||
        (req_len != `SMH_RST_WORD && req_len < `SMH_XFL_LEN));

    ////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole framer.
    always_comb begin
        n = q;
        n.err = 1'b0;
        if (adv) begin
            n.vld = 1'b0;
        end
        case (q.st)
            SMH_IDLE: begin
                if (req_valid && bad) begin
                    n.err = 1'b1;
                end else if (req_valid) begin
                    // Protocol, reserved and vendor kinds pass unchanged.
                    n.kind = req_kind;
                    n.flg = flag_octet;
                    n.len = req_len;
                    n.rem = req_len;
                    n.le = req_le;
                    n.xflg = (req_kind == `SMH_KIND_DATA);
                    // Zero length on other kinds runs to end of message when req_last is set.
                    n.open_end = (req_len == `SMH_RST_WORD) &&
                        !zero_ok && req_last;
                    n.idx = `SMH_HDR_KIND;
                    n.st = SMH_HDR;
                    if (req_kind == `SMH_KIND_HEARTBEAT) begin
                        n.hb_owed = 1'b0;
                    end
                end
            end
            SMH_HDR: begin
                if (adv) begin
                    n.vld = 1'b1;
                    n.lst = 1'b0;
                    n.idx = q.idx + 2'h1;
                    case (q.idx)
                        `SMH_HDR_KIND: n.dat = q.kind;
                        `SMH_HDR_FLAGS: n.dat = q.flg;
                        `SMH_HDR_LEN_A: n.dat = q.le ? q.len[7:0] :
                            q.len[15:8];
                        default: n.dat = q.le ? q.len[15:8] : q.len[7:0];
                    endcase
                    if (q.idx == `SMH_HDR_LEN_B) begin
                        n.idx = `SMH_HDR_KIND;
                        if (q.xflg && (q.rem != `SMH_RST_WORD || q.open_end))
                        begin
                            n.st = SMH_XFL;
                        end else if (q.rem == `SMH_RST_WORD && !q.open_end)
                        begin
                            n.lst = 1'b1;
                            n.st = SMH_IDLE;
                        end else begin
                            n.st = SMH_BODY;
                        end
                    end
                end
            end
            SMH_XFL: begin
                // Two zero octets of extra flags lead the data contents.
                if (adv) begin
                    n.vld = 1'b1;
                    n.lst = 1'b0;
                    n.dat = `SMH_XFL_BYTE;
                    n.idx = q.idx + 2'h1;
                    if (!q.open_end) begin
                        n.rem = q.rem - 16'h0001;
                    end
                    if (q.idx == `SMH_HDR_FLAGS) begin
                        n.idx = `SMH_HDR_KIND;
                        if (q.rem == 16'h0001 && !q.open_end) begin
                            n.lst = 1'b1;
                            n.st = SMH_IDLE;
                        end else begin
                            n.st = SMH_BODY;
                        end
                    end
                end
            end
            SMH_BODY: begin
                if (adv && pl_valid) begin
                    n.vld = 1'b1;
                    // Contents, offset fields included, go out untouched.
                    n.dat = pl_data;
                    if (q.open_end) begin
                        n.lst = pl_last;
                        if (pl_last) begin
                            n.st = SMH_IDLE;
                        end
                    end else begin
                        n.rem = q.rem - 16'h0001;
                        n.lst = (q.rem == 16'h0001);
                        // A counted body never runs past its length field.
                        if (q.rem == 16'h0001) begin
                            n.st = SMH_IDLE;
                        end
                    end
                end
            end
            default: begin
                n.st = SMH_IDLE;
            end
        endcase
        // A new demand wins over the clear by a heartbeat in one cycle.
        if (ack_rcv && !ack_final) begin
            n.hb_owed = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register; clock enable low freezes everything.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on the framer's own behaviour.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_frame_end;
        q.vld && q.lst && (q.st == SMH_IDLE);
    endsequence

    sequence s_counted_tail;
        ce && (q.st == SMH_BODY) && !q.open_end &&
            (q.rem == 16'h0001) && pl_valid && pl_ready;
    endsequence

    sequence s_open_tail;
        ce && (q.st == SMH_BODY) && q.open_end && pl_valid &&
            pl_ready && pl_last;
    endsequence

    property p_kind_first;
        (q.st == SMH_HDR && q.idx == `SMH_HDR_FLAGS && q.vld) |->
            q.dat == q.kind;
    endproperty
    a_kind_first: assert property (p_kind_first)
        else $error("First header octet is not the kind code.");

    property p_flags_second;
        (q.st == SMH_HDR && q.idx == `SMH_HDR_LEN_A && q.vld) |->
            q.dat == q.flg;
    endproperty
    a_flags_second: assert property (p_flags_second)
        else $error("Second header octet is not the flags.");

    property p_len_order;
        (q.st == SMH_HDR && q.idx == `SMH_HDR_LEN_B && q.vld) |->
            q.dat == (q.le ? q.len[7:0] : q.len[15:8]);
    endproperty
    a_len_order: assert property (p_len_order)
        else $error("Length octet not in selected byte order.");

    property p_endian_bit;
        (q.st != SMH_IDLE) |-> q.flg[`SMH_FLG_ENDIAN] == q.le;
    endproperty
    a_endian_bit: assert property (p_endian_bit)
        else $error("Endianness flag differs from byte order.");

    property p_unused_zero;
        (q.st != SMH_IDLE && q.kind != `SMH_KIND_DATA &&
            q.kind != `SMH_KIND_ACKNACK &&
            q.kind != `SMH_KIND_HEARTBEAT) |-> q.flg[7:1] == 7'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unused flag bit sent as one.");

    property p_data_kind;
        (q.st != SMH_IDLE) |-> q.xflg == (q.kind == `SMH_KIND_DATA);
    endproperty
    a_data_kind: assert property (p_data_kind)
        else $error("Extra flags decision disagrees with kind code.");

    property p_xfl_zero;
        (q.st == SMH_XFL && q.idx == `SMH_HDR_FLAGS && q.vld) |->
            q.dat == `SMH_XFL_BYTE;
    endproperty
    a_xfl_zero: assert property (p_xfl_zero)
        else $error("Extra flags octet is not zero.");

    property p_counted_end;
        s_counted_tail |=> s_frame_end;
    endproperty
    a_counted_end: assert property (p_counted_end)
        else $error("Counted contents did not end the submessage.");

    property p_open_end;
        s_open_tail |=> s_frame_end;
    endproperty
    a_open_end: assert property (p_open_end)
        else $error("Open-ended submessage did not end on last byte.");

    property p_hb_demand;
        (ce && ack_rcv && !ack_final) |=> hb_owed;
    endproperty
    a_hb_demand: assert property (p_hb_demand)
        else $error("Acknack without final bit raised no demand.");

    property p_dk_refused;
        (ce && q.st == SMH_IDLE && req_valid &&
            req_kind == `SMH_KIND_DATA && req_dpres && req_kpres) |=>
            (req_err && q.st == SMH_IDLE);
    endproperty
    a_dk_refused: assert property (p_dk_refused)
        else $error("Data request with data and key was accepted.");

endmodule

// file: verification/smh_remote_model.sv
// Remote participant model: takes framed octets and sends acknacks.
// Assumes one framer on ref_clk drives the octet stream.
`timescale 1ns/100ps

module smh_remote_model (
    input wire logic ref_clk,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic ack_rcv,
    output logic ack_final
);
    logic [7:0] got[$];
    logic [7:0] flg;
    logic [7:0] lb;
    logic [15:0] ln = 16'h0000;
    int mode = 1;
    int cnt = 0;
    int pos = 0;
    int n_frm = 0;
    int n_bad = 0;

    // Lines start idle with the stream accepted.
    initial begin
        tx_ready = 1'b1;
        ack_rcv = 1'b0;
        ack_final = 1'b1;
    end

    ////////////////////////////////////////
    // Splits octets into submessages and checks each nonzero length field.
    always @(posedge ref_clk) begin
        if (tx_valid === 1'b1 && tx_ready) begin
            got.push_back(tx_data);
            case (pos)
                1: flg = tx_data;
                2: lb = tx_data;
                3: ln = flg[0] ? {tx_data, lb} : {lb, tx_data};
                default: ;
            endcase
            if (tx_last === 1'b1) begin
                // A zero length is header only or open to message end.
                if (ln != 16'h0000 && pos != ln + 3)
                    n_bad++;
                n_frm++;
                pos = 0;
            end else begin
                pos++;
            end
        end
        cnt++;
        // Ready moves on the edge itself, so every reader sees it settled.
        tx_ready <= (cnt % mode) == 0; // One octet in every mode cycles.
    end

    // Sends one acknack indication for a single cycle.
    task automatic send_ack(input logic f);
        ack_rcv = 1'b1;
        ack_final = f;
        @(posedge ref_clk);
        #1;
        ack_rcv = 1'b0;
        ack_final = ~f;
    endtask
endmodule

// file: verification/smh_framer_test.sv
// Testbench of the submessage framer: kinds, flags, lengths, refusals.
// Assumes the design files and the remote model are compiled first.
`timescale 1ns/100ps

module smh_framer_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    logic [7:0] req_kind = 8'h00;
    logic [15:0] req_len = 16'h0000;
    logic req_last = 1'b0;
    logic [6:0] rf = 7'h00; // Order: nstd kpres dpres qos live fin le.
    logic pl_valid = 1'b0;
    logic [7:0] pl_data = 8'h00;
    logic pl_last = 1'b0;
    logic req_ready;
    logic req_err;
    logic pl_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic tx_ready;
    logic ack_rcv;
    logic ack_final;
    logic hb_owed;
    int miscompares = 0;
    int n_tests = 0;
    logic [15:0] kt[17] = '{16'h7F06, 16'h7F07, 16'h0101, 16'h0108,
        16'h0109, 16'h010C, 16'h010D, 16'h010E, 16'h010F, 16'h0112,
        16'h0113, 16'h0116, 16'h7E00, 16'h7E30, 16'h7E3F, 16'h7E80,
        16'h7EFF};

    // Framer under test and the remote participant on its stream.
    smh_framer u_smh_framer (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .req_valid(req_valid),
        .req_ready(req_ready),
        .req_kind(req_kind),
        .req_len(req_len),
        .req_last(req_last),
        .req_le(rf[0]),
        .req_fin(rf[1]),
        .req_live(rf[2]),
        .req_qos(rf[3]),
        .req_dpres(rf[4]),
        .req_kpres(rf[5]),
        .req_nstd(rf[6]),
        .req_err(req_err),
        .pl_valid(pl_valid),
        .pl_ready(pl_ready),
        .pl_data(pl_data),
        .pl_last(pl_last),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_last(tx_last),
        .tx_ready(tx_ready),
        .ack_rcv(ack_rcv),
        .ack_final(ack_final),
        .hb_owed(hb_owed)
    );
    smh_remote_model u_smh_remote_model (
        .ref_clk(ref_clk),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_last(tx_last),
        .tx_ready(tx_ready),
        .ack_rcv(ack_rcv),
        .ack_final(ack_final)
    );

    // Free running clock of 20 ns.
    always #10 ref_clk = ~ref_clk;

    ////////////////////////////////////////
    // Comparison, timing and closing helpers.
    task automatic chk_val(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tmo(input string nm);
        miscompares++;
        $display("Error %s expected done seen timeout", nm);
        report_and_stop();
    endtask

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    // Holds the current request until the chosen ready is seen high.
    task automatic hs(input logic w);
        int t;
        t = 0;
        while ((w ? pl_ready : req_ready) !== 1'b1) begin
            tick();
            t++;
            if (t > 3000)
                tmo("handshake");
        end
        tick();
    endtask

    task automatic put_req(input logic [7:0] k, input logic [15:0] len,
            input logic lst, input logic [6:0] f);
        req_valid = 1'b1;
        req_kind = k;
        req_len = len;
        req_last = lst;
        rf = f;
        hs(1'b0);
        req_valid = 1'b0;
        req_kind = ~k;
    endtask

    // Flags octet worked out from the kind and the request bits.
    function automatic logic [7:0] exp_flags(input logic [7:0] k,
            input logic [6:0] f);
        logic [7:0] e;
        e = {7'h00, f[0]};
        case (k)
            8'h06: e[1] = f[1];
            8'h07: e[2:1] = f[2:1];
            8'h15: e[4:1] = f[6:3];
            default: ;
        endcase
        return e;
    endfunction

    // Sends one submessage with npl payload octets and checks the stream.
    task automatic run(input logic [7:0] k, input logic [15:0] len,
            input logic lst, input logic [6:0] f, input int npl);
        logic [7:0] eq[$];
        logic [7:0] gq[$];
        int b;
        int nf;
        int t;
        b = u_smh_remote_model.got.size();
        nf = u_smh_remote_model.n_frm;
        eq.push_back(k);
        eq.push_back(exp_flags(k, f));
        eq.push_back(f[0] ? len[7:0] : len[15:8]);
        eq.push_back(f[0] ? len[15:8] : len[7:0]);
        if (k == 8'h15 && (len != 16'h0000 || lst)) begin
            eq.push_back(8'h00);
            eq.push_back(8'h00);
        end
        for (int i = 0; i < npl; i++)
            eq.push_back(8'(i) ^ 8'hA5);
        put_req(k, len, lst, f);
        for (int i = 0; i < npl; i++) begin
            pl_valid = 1'b1;
            pl_data = 8'(i) ^ 8'hA5;
            pl_last = i == npl - 1;
            hs(1'b1);
        end
        pl_valid = 1'b0;
        pl_last = 1'b0;
        t = 0;
        while (u_smh_remote_model.n_frm == nf) begin
            tick();
            t++;
            if (t > 3000)
                tmo("frame");
        end
        gq = u_smh_remote_model.got;
        chk_cnt("octets", eq.size(), gq.size() - b);
        foreach (eq[i])
            chk_val("octet", 16'(eq[i]), 16'(gq[b + i]));
    endtask

    ////////////////////////////////////////
    // Scenarios.
    task automatic t_kinds();
        foreach (kt[i])
            run(kt[i][7:0], 16'h0000, 1'b0, kt[i][14:8],
                0);
    endtask

    // Clock enable low holds the framer and its stream, then it resumes.
    task automatic t_freeze();
        int b;
        int t;
        b = u_smh_remote_model.got.size();
        put_req(8'h08, 16'h0000, 1'b0, 7'h01);
        ce = 1'b0;
        repeat (3) tick();
        chk_val("tx_valid frozen", 16'h0000, 16'(tx_valid));
        chk_cnt("frozen octets", b, u_smh_remote_model.got.size());
        ce = 1'b1;
        t = 0;
        while (u_smh_remote_model.got.size() < b + 4) begin
            tick();
            t++;
            if (t > 3000)
                tmo("freeze");
        end
        chk_val("kind after freeze", 16'h0008,
            16'(u_smh_remote_model.got[b]));
        chk_val("flags after freeze", 16'h0001,
            16'(u_smh_remote_model.got[b + 1]));
        ce = 1'b0;
        tick();
        chk_val("req_ready frozen", 16'h0000, 16'(req_ready));
        ce = 1'b1;
        tick();
    endtask

    task automatic t_data();
        u_smh_remote_model.mode = 4;
        run(8'h15, 16'h0005, 1'b0, 7'h18, 3);
        run(8'h15, 16'h0004, 1'b0, 7'h61, 2);
        run(8'h08, 16'h0102, 1'b0, 7'h01, 258);
        u_smh_remote_model.mode = 1;
    endtask

    task automatic t_open();
        run(8'h15, 16'h0000, 1'b1, 7'h11, 5);
        run(8'h08, 16'h0000, 1'b1, 7'h00, 3);
        run(8'h01, 16'h0000, 1'b1, 7'h01, 0);
        run(8'h09, 16'h0000, 1'b1, 7'h00, 0);
    endtask

    task automatic t_refuse();
        int b;
        b = u_smh_remote_model.got.size();
        put_req(8'h15, 16'h0008, 1'b0, 7'h30);
        chk_val("req_err both", 16'h0001, 16'(req_err));
        tick();
        put_req(8'h15, 16'h0001, 1'b0, 7'h10);
        chk_val("req_err short", 16'h0001, 16'(req_err));
        repeat (4) tick();
        chk_cnt("refused octets", b, u_smh_remote_model.got.size());
        chk_val("req_ready", 16'h0001, 16'(req_ready));
    endtask

    task automatic t_ack();
        u_smh_remote_model.send_ack(1'b1);
        chk_val("hb_owed final", 16'h0000, 16'(hb_owed));
        tick();
        u_smh_remote_model.send_ack(1'b0);
        chk_val("hb_owed", 16'h0001, 16'(hb_owed));
        run(8'h07, 16'h0000, 1'b0, 7'h05, 0);
        chk_val("hb_owed clear", 16'h0000, 16'(hb_owed));
    endtask

    // Main sequence: reset, then every scenario, then the verdict.
    initial begin
        repeat (10) tick();
        chk_val("tx_valid reset", 16'h0000, 16'(tx_valid));
        chk_val("hb_owed reset", 16'h0000, 16'(hb_owed));
        rst = 1'b0;
        t_kinds();
        t_data();
        t_open();
        t_refuse();
        t_ack();
        t_freeze();
        chk_cnt("length errors", 0, u_smh_remote_model.n_bad);
        report_and_stop();
    end
endmodule
